// >>> src/tcrm_top.sv
`timescale 1ns/1ps
`include "tcrm_map.svh"
module tcrm_top (
   input wire logic clock, // 200 MHz clock.
   input wire logic rstn, // Synchronous reset, active low.
   input wire logic cyc_valid, // Target bus cycle valid.
   input wire tcrm_pkg::tcrm_cyc_t cyc, // Target bus cycle contents.
   input wire logic prog_halt, // Pulse when the user program halts.
   input wire logic [7:0] reg_addr, // Register byte address.
   input wire logic [31:0] reg_wdata, // Register write data.
   input wire logic reg_wr, // Register write strobe.
   input wire logic reg_rd, // Register read strobe.
   output logic [31:0] reg_rdata, // Read data, cycle after strobe.
   output logic trace_done, // Measurement complete.
   output logic trace_busy // Measurement in progress.
);
   // ---------------------------------------------------------------
   // Functions.
   // ---------------------------------------------------------------
   // Matches one bus cycle against an event detector setup.
   function automatic logic ev_match(input tcrm_pkg::tcrm_ev_t e,
                                     input tcrm_pkg::tcrm_cyc_t c);
      logic dir_ok;
      dir_ok = c.fetch | (c.wr ? e.dir[1] : e.dir[0]);
      return e.en && (c.fetch == e.fetch) && dir_ok && (c.addr >= e.lo) &&
             (c.addr <= e.hi) && (!e.dcmp || (c.data == e.data));
   endfunction

   // Register select, used by write and command decode.
   function automatic logic sel(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   // ---------------------------------------------------------------
   // Configuration registers.
   // ---------------------------------------------------------------
   tcrm_pkg::tcrm_mode_t mode_r;
   tcrm_pkg::tcrm_filt_t filt_r;
   tcrm_pkg::tcrm_comb_t comb_r;
   tcrm_pkg::tcrm_ev_t ev_r [2];
   logic span_sel_r;
   logic [15:0] tidx_r;
   logic [9:0] midx_r;
   logic [19:0] mst_r [4];
   logic [2:0] mcnt_r [4];
   logic cmd_start, cmd_susp, cmd_resume, cmd_mclr;

   assign cmd_start = reg_wr & sel(reg_addr, `TCRM_A_CTRL) &
                      reg_wdata[`TCRM_C_START];
   assign cmd_susp = reg_wr & sel(reg_addr, `TCRM_A_CTRL) &
                     reg_wdata[`TCRM_C_SUSP];
   assign cmd_resume = reg_wr & sel(reg_addr, `TCRM_A_CTRL) &
                       reg_wdata[`TCRM_C_RESUME];
   assign cmd_mclr = reg_wr & sel(reg_addr, `TCRM_A_CTRL) &
                     reg_wdata[`TCRM_C_MCLR];

   // Mode, filter, combiner and index registers.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         mode_r <= tcrm_pkg::TM_BREAK;
         filt_r <= tcrm_pkg::TF_TOTAL;
         comb_r <= tcrm_pkg::TC_OR;
         span_sel_r <= 1'b0;
         tidx_r <= 16'h0000;
         midx_r <= 10'h000;
      end else if (reg_wr) begin
         if (sel(reg_addr, `TCRM_A_MODE)) begin
            mode_r <= tcrm_pkg::tcrm_mode_t'(reg_wdata[4:0]);
            filt_r <= tcrm_pkg::tcrm_filt_t'(reg_wdata[`TCRM_F_FILT]);
            span_sel_r <= reg_wdata[`TCRM_F_SPAN];
            comb_r <= tcrm_pkg::tcrm_comb_t'(reg_wdata[`TCRM_F_COMB]);
         end
         if (sel(reg_addr, `TCRM_A_TIDX)) tidx_r <= reg_wdata[15:0];
         if (sel(reg_addr, `TCRM_A_MIDX)) midx_r <= reg_wdata[9:0];
      end
   end

   // ---------------------------------------------------------------
   // Event detectors and combiner.
   // ---------------------------------------------------------------
   logic [1:0] ev_m, ev_hit, ev_occ_r, ev_on;
   logic [7:0] ev_cnt_r [2];
   logic fire;

   generate
      for (genvar i = 0; i < 2; i++) begin : g_ev
         localparam logic [7:0] OFS = (i == 0) ? `TCRM_A_EV0 : `TCRM_A_EV1;
         // Three words per detector: range low, range high, setup.
         always_ff @(posedge clock) begin
            if (!rstn) begin
               ev_r[i] <= '0;
            end else if (reg_wr) begin
               if (sel(reg_addr, OFS)) ev_r[i].lo <= reg_wdata[19:0];
               if (sel(reg_addr, OFS + 8'h04)) ev_r[i].hi <= reg_wdata[19:0];
               if (sel(reg_addr, OFS + 8'h08)) begin
                  ev_r[i].data <= reg_wdata[7:0];
                  ev_r[i].dcmp <= reg_wdata[8];
                  ev_r[i].dir <= reg_wdata[10:9];
                  ev_r[i].fetch <= reg_wdata[11];
                  ev_r[i].en <= reg_wdata[12];
                  ev_r[i].pass <= reg_wdata[23:16];
               end
            end
         end
         assign ev_m[i] = cyc_valid & ev_match(ev_r[i], cyc);
         assign ev_on[i] = ev_r[i].en;
         // Pass counting: the event counts as met on its pass-th match.
         assign ev_hit[i] = ev_m[i] & ((ev_cnt_r[i] + 8'h01) >= ev_r[i].pass);
         always_ff @(posedge clock) begin
            if (!rstn || cmd_start || fire) begin
               ev_cnt_r[i] <= 8'h00;
               ev_occ_r[i] <= 1'b0;
            end else if (ev_m[i] && !ev_occ_r[i]) begin
               ev_cnt_r[i] <= ev_cnt_r[i] + 8'h01;
               ev_occ_r[i] <= ev_hit[i];
            end
         end
      end
   endgenerate

   // Combiner for the trace trigger; in break mode a fire does not end recording.
   always_comb begin
      case (comb_r)
         tcrm_pkg::TC_AND: fire = |ev_on &
                                  &((ev_occ_r | ev_hit) | ~ev_on);
         tcrm_pkg::TC_SAME: fire = |ev_on & &(ev_m | ~ev_on);
         tcrm_pkg::TC_OR: fire = |(ev_hit & ev_on);
         default: fire = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // Write filter.
   // ---------------------------------------------------------------
   logic span_r, in_span, cond, filt_pass;

   // Span opens on event 0 and closes on event 1; opening wins.
   always_ff @(posedge clock) begin
      if (!rstn || cmd_start) span_r <= 1'b0;
      else if (ev_m[0]) span_r <= 1'b1;
      else if (ev_m[1]) span_r <= 1'b0;
   end
   assign in_span = ev_m[0] | span_r;
   assign cond = span_sel_r ? in_span : |ev_m;

   always_comb begin
      case (filt_r)
         tcrm_pkg::TF_TOTAL: filt_pass = 1'b1;
         tcrm_pkg::TF_PICK: filt_pass = cond;
         tcrm_pkg::TF_EXCL: filt_pass = ~cond;
         default: filt_pass = 1'b1;
      endcase
   end

   // ---------------------------------------------------------------
   // Trace sequencer and memory.
   // ---------------------------------------------------------------
   tcrm_pkg::tcrm_state_t st_r;
   logic susp_r, wrap_r, rec_phase, store, post_end;
   logic [15:0] wptr_r, post_r;
   logic [29:0] tmem [0:65535];
   logic [29:0] tq_r;

   // Recording phase; the trigger cycle is excluded in before mode.
   assign rec_phase = (st_r == tcrm_pkg::TS_POST) ||
                      ((st_r == tcrm_pkg::TS_REC) &&
                       (mode_r != tcrm_pkg::TM_AFTER) &&
                       !(fire && mode_r == tcrm_pkg::TM_BEFORE) &&
                       !prog_halt);
   assign store = rec_phase & cyc_valid & filt_pass & ~susp_r;
   assign post_end = store && (st_r == tcrm_pkg::TS_POST) &&
                     (post_r == 16'h0000);

   // Measurement state machine.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         st_r <= tcrm_pkg::TS_IDLE;
         post_r <= 16'h0000;
      end else begin
         case (st_r)
            tcrm_pkg::TS_IDLE, tcrm_pkg::TS_DONE: begin
               if (cmd_start && mode_r == tcrm_pkg::TM_FULL) begin
                  st_r <= tcrm_pkg::TS_POST;
                  post_r <= `TCRM_TR_LAST;
               end else if (cmd_start) begin
                  st_r <= tcrm_pkg::TS_REC;
               end
            end
            tcrm_pkg::TS_REC: begin
               if (prog_halt) begin
                  st_r <= tcrm_pkg::TS_DONE;
               end else if (fire) begin
                  case (mode_r)
                     tcrm_pkg::TM_BEFORE: st_r <= tcrm_pkg::TS_DONE;
                     tcrm_pkg::TM_ABOUT: begin
                        st_r <= tcrm_pkg::TS_POST;
                        post_r <= `TCRM_TR_HALF;
                     end
                     tcrm_pkg::TM_AFTER: begin
                        st_r <= tcrm_pkg::TS_POST;
                        post_r <= `TCRM_TR_LAST;
                     end
                     default: st_r <= tcrm_pkg::TS_REC;
                  endcase
               end
            end
            tcrm_pkg::TS_POST: begin
               if (prog_halt || post_end) st_r <= tcrm_pkg::TS_DONE;
               else if (store) post_r <= post_r - 16'h0001;
            end
            default: st_r <= tcrm_pkg::TS_IDLE;
         endcase
      end
   end

   // Suspend and resume of the running measurement.
   always_ff @(posedge clock) begin
      if (!rstn || cmd_start || cmd_resume) susp_r <= 1'b0;
      else if (cmd_susp) susp_r <= 1'b1;
   end

   // Circular write pointer; oldest entry is at the pointer once wrapped.
   always_ff @(posedge clock) begin
      if (!rstn || cmd_start) begin
         wptr_r <= 16'h0000;
         wrap_r <= 1'b0;
      end else if (store) begin
         wptr_r <= wptr_r + 16'h0001;
         if (wptr_r == `TCRM_TR_LAST) wrap_r <= 1'b1;
      end
   end

   // Trace memory, one write and one host read port.
   always_ff @(posedge clock) begin
      if (store) tmem[wptr_r] <= {cyc.fetch, cyc.wr, cyc.addr, cyc.data};
      tq_r <= tmem[tidx_r];
   end

   assign trace_done = (st_r == tcrm_pkg::TS_DONE);
   assign trace_busy = (st_r == tcrm_pkg::TS_REC) ||
                       (st_r == tcrm_pkg::TS_POST);

   // ---------------------------------------------------------------
   // RAM monitor.
   // ---------------------------------------------------------------
   logic [7:0] mmem [0:1023];
   logic [1023:0] mrf_r, mwf_r;
   logic mhit;
   logic [9:0] midx;
   logic [7:0] mq_r;

   // Region setup; region 0 covers the default 1K window.
   always_ff @(posedge clock) begin
      for (int i = 0; i < 4; i++) begin
         if (!rstn) begin
            mst_r[i] <= (i == 0) ? `TCRM_MON_DEF_START : 20'h00000;
            mcnt_r[i] <= (i == 0) ? `TCRM_MON_DEF_CNT : 3'h0;
         end else if (reg_wr && sel(reg_addr, `TCRM_A_MREG + 8'(4 * i))) begin
            mst_r[i] <= reg_wdata[19:0];
            mcnt_r[i] <= reg_wdata[22:20];
         end
      end
   end

   // Region i fills shadow blocks i onward; the lowest region wins.
   always_comb begin
      logic [19:0] off;
      logic [10:0] pos;
      off = 20'h00000;
      pos = 11'h000;
      mhit = 1'b0;
      midx = 10'h000;
      for (int i = 3; i >= 0; i--) begin
         off = cyc.addr - mst_r[i];
         pos = 11'(i * 256) + off[10:0];
         if (cyc.addr >= mst_r[i] && off < 20'({mcnt_r[i], 8'h00}) &&
             pos < `TCRM_MON_SIZE) begin
            mhit = cyc_valid & ~cyc.fetch;
            midx = pos[9:0];
         end
      end
   end

   // Shadow data and flags; a hit in the clearing cycle survives.
   always_ff @(posedge clock) begin
      if (!rstn || cmd_mclr) begin
         mrf_r <= '0;
         mwf_r <= '0;
      end
      if (rstn && mhit && cyc.wr) mwf_r[midx] <= 1'b1;
      if (rstn && mhit && !cyc.wr) mrf_r[midx] <= 1'b1;
   end
   always_ff @(posedge clock) begin
      if (mhit) mmem[midx] <= cyc.data;
      mq_r <= mmem[midx_r];
   end

   // ---------------------------------------------------------------
   // Register read path.
   // ---------------------------------------------------------------
   logic [7:0] raddr_r;
   logic rd_r;
   always_ff @(posedge clock) begin
      if (!rstn) begin
         raddr_r <= 8'h00;
         rd_r <= 1'b0;
      end else begin
         raddr_r <= reg_addr;
         rd_r <= reg_rd;
      end
   end

   // Read data is valid only in the cycle after the strobe.
   always_comb begin
      reg_rdata = 32'h00000000;
      if (rd_r) begin
         case (raddr_r)
            `TCRM_A_MODE: reg_rdata = {20'h00000, comb_r, span_sel_r,
                                       filt_r, mode_r};
            `TCRM_A_STAT: reg_rdata = {wptr_r, 8'h00, wrap_r, susp_r,
                                       fire, span_r, st_r};
            `TCRM_A_TDAT: reg_rdata = trace_done ?
                                      {2'h0, tq_r} : 32'h00000000;
            `TCRM_A_MDAT: reg_rdata = {22'h000000, mwf_r[midx_r],
                                       mrf_r[midx_r], mq_r};
            // Region setup reads back so software can see the default.
            `TCRM_A_MREG: reg_rdata = {9'h000, mcnt_r[0], mst_r[0]};
            `TCRM_A_MREG + 8'h04: reg_rdata = {9'h000, mcnt_r[1], mst_r[1]};
            `TCRM_A_MREG + 8'h08: reg_rdata = {9'h000, mcnt_r[2], mst_r[2]};
            `TCRM_A_MREG + 8'h0C: reg_rdata = {9'h000, mcnt_r[3], mst_r[3]};
            default: reg_rdata = 32'h00000000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Assertions.
   // ---------------------------------------------------------------
   // All checks run on the one clock and are off during reset.
   default clocking cb_chk @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_about_trig;
      st_r == tcrm_pkg::TS_REC && mode_r == tcrm_pkg::TM_ABOUT &&
      fire && !prog_halt;
   endsequence
   sequence s_post_half;
      st_r == tcrm_pkg::TS_POST && post_r == `TCRM_TR_HALF;
   endsequence

   a_halt_ends_rec: assert property (
      st_r == tcrm_pkg::TS_REC && prog_halt |=> trace_done)
      else $error("halt did not end the measurement");
   a_before_stop: assert property (
      st_r == tcrm_pkg::TS_REC && mode_r == tcrm_pkg::TM_BEFORE && fire
      |-> !store ##1 trace_done)
      else $error("before mode did not stop at trigger");
   a_about_half: assert property (
      s_about_trig |=> s_post_half)
      else $error("about mode did not load the half count");
   a_post_done: assert property (
      post_end |=> trace_done && !store)
      else $error("post count did not end recording");
   a_total_store: assert property (
      filt_r == tcrm_pkg::TF_TOTAL && rec_phase && cyc_valid && !susp_r
      |-> store ##1 wptr_r == $past(wptr_r) + 16'h0001)
      else $error("total filter dropped a cycle");
   a_pick_block: assert property (
      filt_r == tcrm_pkg::TF_PICK && !cond |-> !store)
      else $error("pick-up stored a failing cycle");
   a_excl_block: assert property (
      filt_r == tcrm_pkg::TF_EXCL && cond |-> !store)
      else $error("exclude stored a matching cycle");
   a_susp_hold: assert property (
      susp_r && !cmd_start |=> wptr_r == $past(wptr_r))
      else $error("recording went on while suspended");
   a_mon_write: assert property (
      mhit && cyc.wr |=> mwf_r[$past(midx)])
      else $error("monitor write flag not set");
   a_wrap_flag: assert property (
      store && wptr_r == `TCRM_TR_LAST |=> wrap_r && wptr_r == 16'h0000)
      else $error("trace pointer did not wrap");
   a_read_gate: assert property (
      reg_rd && reg_addr == `TCRM_A_TDAT
      |=> trace_done || reg_rdata == 32'h00000000)
      else $error("trace read before completion");
endmodule // tcrm_top

// >>> src/tcrm_map.svh
`ifndef TCRM_MAP_SVH
`define TCRM_MAP_SVH
// -----------------------------------------------------------------
// Register byte offsets.
// -----------------------------------------------------------------
`define TCRM_A_CTRL 8'h00
`define TCRM_A_MODE 8'h04
`define TCRM_A_STAT 8'h08
`define TCRM_A_EV0 8'h10
`define TCRM_A_EV1 8'h20
`define TCRM_A_TIDX 8'h30
`define TCRM_A_TDAT 8'h34
`define TCRM_A_MREG 8'h40
`define TCRM_A_MIDX 8'h50
`define TCRM_A_MDAT 8'h54
// -----------------------------------------------------------------
// Control command bits and mode fields.
// -----------------------------------------------------------------
`define TCRM_C_START 0
`define TCRM_C_SUSP 1
`define TCRM_C_RESUME 2
`define TCRM_C_MCLR 3
`define TCRM_F_FILT 7:5
`define TCRM_F_SPAN 8
`define TCRM_F_COMB 11:9
// -----------------------------------------------------------------
// Depths and reset values.
// -----------------------------------------------------------------
`define TCRM_TR_LAST 16'hFFFF
`define TCRM_TR_HALF 16'h7FFF
`define TCRM_BLK 11'h100
`define TCRM_MON_SIZE 11'h400
`define TCRM_MON_DEF_START 20'h00400
`define TCRM_MON_DEF_CNT 3'h4
`endif

// >>> src/tcrm_pkg.sv
package tcrm_pkg;
   // Observed target bus cycle.
   typedef struct packed {
      logic fetch;
      logic wr;
      logic [19:0] addr;
      logic [7:0] data;
   } tcrm_cyc_t;
   // Event detector setup.
   typedef struct packed {
      logic [7:0] pass;
      logic en;
      logic fetch;
      logic [1:0] dir;
      logic dcmp;
      logic [7:0] data;
      logic [19:0] lo;
      logic [19:0] hi;
   } tcrm_ev_t;
   typedef enum logic [4:0] {
      TM_BREAK = 5'h01, TM_BEFORE = 5'h02, TM_ABOUT = 5'h04,
      TM_AFTER = 5'h08, TM_FULL = 5'h10
   } tcrm_mode_t;
   typedef enum logic [2:0] {
      TF_TOTAL = 3'h1, TF_PICK = 3'h2, TF_EXCL = 3'h4
   } tcrm_filt_t;
   typedef enum logic [2:0] {
      TC_AND = 3'h1, TC_SAME = 3'h2, TC_OR = 3'h4
   } tcrm_comb_t;
   typedef enum logic [3:0] {
      TS_IDLE = 4'h1, TS_REC = 4'h2, TS_POST = 4'h4, TS_DONE = 4'h8
   } tcrm_state_t;
endpackage

// >>> bench/tcrm_bus_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Target bus model.
// -----------------------------------------------------------------
module tcrm_bus_model (
   input wire logic clock, // Shared target clock.
   input wire logic run, // Issue one bus cycle per clock while high.
   input wire logic wr, // Direction of the issued cycles.
   input wire logic [19:0] base, // Address of the first cycle of a burst.
   output logic cyc_valid, // Bus cycle valid.
   output tcrm_pkg::tcrm_cyc_t cyc // Bus cycle contents.
);
   logic [16:0] k_r;
   initial begin
      cyc_valid = 1'b0;
      cyc = '0;
      k_r = 17'h0;
   end
   // Burst of data cycles with address base plus count, data the count.
   // Idle lines toggle so stale contents can never look like a cycle.
   always @(posedge clock) begin
      if (run) begin
         cyc_valid <= 1'b1;
         cyc <= {1'b0, wr, base + {3'h0, k_r}, k_r[7:0]};
         k_r <= k_r + 17'h1;
      end else begin
         cyc_valid <= 1'b0;
         cyc <= ~cyc;
         k_r <= 17'h0;
      end
   end
endmodule // tcrm_bus_model

// >>> bench/tcrm_top_tb_top.sv
`timescale 1ns/1ps
`include "tcrm_map.svh"
module tcrm_top_tb_top;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic prog_halt = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic trace_done;
   logic trace_busy;
   logic cyc_valid;
   tcrm_pkg::tcrm_cyc_t cyc;
   logic m_run = 1'b0;
   logic m_wr = 1'b0;
   logic [19:0] m_base = 20'h0;
   int n_errors = 0;
   int compares = 0;
   int cyc_cnt = 0;
   logic [31:0] d;
   // 200 MHz clock.
   always #2.5 clock = ~clock;
   tcrm_top uut (.clock(clock), .rstn(rstn), .cyc_valid(cyc_valid),
      .cyc(cyc), .prog_halt(prog_halt), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .trace_done(trace_done),
      .trace_busy(trace_busy));
   tcrm_bus_model bus_m (.clock(clock), .run(m_run), .wr(m_wr),
      .base(m_base), .cyc_valid(cyc_valid), .cyc(cyc));
   // -----------------------------------------------------------------
   // Helpers.
   // -----------------------------------------------------------------
   task automatic print_verdict();
      if (n_errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // Ends any running measurement with a one-cycle program halt pulse.
   task automatic halt();
      @(posedge clock);
      prog_halt <= 1'b1;
      @(posedge clock);
      prog_halt <= 1'b0;
   endtask
   task automatic bus(input logic [19:0] b, input logic w, input int n);
      @(posedge clock);
      m_base <= b;
      m_wr <= w;
      m_run <= 1'b1;
      repeat (n) @(posedge clock);
      m_run <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   // Starts a measurement in mode m, sends n cycles and checks the pointer.
   task automatic run_case(input logic [31:0] m, input logic [19:0] b,
         input int n, input logic [15:0] exp);
      halt();
      wr_reg(`TCRM_A_MODE, m);
      wr_reg(`TCRM_A_CTRL, 32'h1);
      bus(b, 1'b0, n);
      rd_reg(`TCRM_A_STAT, d);
      chk({16'h0, d[31:16]}, {16'h0, exp});
   endtask
   // -----------------------------------------------------------------
   // Scenarios.
   // -----------------------------------------------------------------
   task automatic t_reset();
      rd_reg(`TCRM_A_STAT, d);
      chk(d, 32'h1);
      rd_reg(`TCRM_A_MODE, d);
      chk(d, 32'h821);
      rd_reg(`TCRM_A_MREG, d);
      chk(d, 32'h0040_0400);
      rd_reg(8'hFC, d);
      chk(d, 32'h0);
   endtask
   task automatic t_monitor();
      wr_reg(`TCRM_A_CTRL, 32'h8);
      bus(20'h00410, 1'b1, 2);
      bus(20'h00420, 1'b0, 1);
      wr_reg(`TCRM_A_MIDX, 32'h10);
      rd_reg(`TCRM_A_MDAT, d);
      chk(d, 32'h200);
      wr_reg(`TCRM_A_MIDX, 32'h11);
      rd_reg(`TCRM_A_MDAT, d);
      chk(d, 32'h201);
      wr_reg(`TCRM_A_MIDX, 32'h20);
      rd_reg(`TCRM_A_MDAT, d);
      chk(d, 32'h100);
      wr_reg(`TCRM_A_MIDX, 32'h30);
      rd_reg(`TCRM_A_MDAT, d);
      chk(d & 32'h300, 32'h0);
      wr_reg(`TCRM_A_MREG, 32'h0010_0400);
      wr_reg(`TCRM_A_MREG + 8'h4, 32'h0010_8000);
      bus(20'h08005, 1'b1, 1);
      wr_reg(`TCRM_A_MIDX, 32'h105);
      rd_reg(`TCRM_A_MDAT, d);
      chk(d, 32'h200);
   endtask
   task automatic t_suspend();
      run_case(32'h830, 20'h00600, 10, 16'd10);
      rd_reg(`TCRM_A_TDAT, d);
      chk(d, 32'h0);
      wr_reg(`TCRM_A_CTRL, 32'h2);
      bus(20'h00600, 1'b0, 5);
      rd_reg(`TCRM_A_STAT, d);
      chk({16'h0, d[31:16]}, 32'd10);
      wr_reg(`TCRM_A_CTRL, 32'h4);
      bus(20'h00600, 1'b0, 3);
      rd_reg(`TCRM_A_STAT, d);
      chk({16'h0, d[31:16]}, 32'd13);
   endtask
   task automatic t_break();
      run_case(32'h821, 20'h00600, 20, 16'd20);
      halt();
      repeat (2) @(posedge clock);
      chk({30'h0, trace_done, trace_busy}, 32'h2);
   endtask
   task automatic t_events();
      wr_reg(`TCRM_A_EV0, 32'h00500);
      wr_reg(`TCRM_A_EV0 + 8'h4, 32'h00503);
      wr_reg(`TCRM_A_EV0 + 8'h8, 32'h0001_1600);
      run_case(32'h822, 20'h004FC, 8, 16'd4);
      chk({31'h0, trace_done}, 32'h1);
      run_case(32'h850, 20'h00500, 8, 16'd4);
      run_case(32'h890, 20'h00500, 8, 16'd4);
      wr_reg(`TCRM_A_EV1, 32'h00505);
      wr_reg(`TCRM_A_EV1 + 8'h4, 32'h00505);
      wr_reg(`TCRM_A_EV1 + 8'h8, 32'h0001_1600);
      run_case(32'h950, 20'h00500, 8, 16'd6);
   endtask
   task automatic t_fill();
      run_case(32'h830, 20'h01000, 65540, 16'h0000);
      chk(d & 32'hFF, 32'h88);
      chk({30'h0, trace_done, trace_busy}, 32'h2);
      wr_reg(`TCRM_A_TIDX, 32'hFFFF);
      rd_reg(`TCRM_A_TDAT, d);
      chk(d, 32'h010F_FFFF);
      wr_reg(`TCRM_A_TIDX, 32'h0);
      rd_reg(`TCRM_A_TDAT, d);
      chk(d, 32'h0010_0000);
      wr_reg(`TCRM_A_TIDX, 32'h1);
      rd_reg(`TCRM_A_TDAT, d);
      chk(d, 32'h0010_0101);
   endtask
   // Cuts a hang short.
   always @(posedge clock) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 90000) begin
         n_errors++;
         print_verdict();
      end
   end
   // Main sequence.
   initial begin
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      t_reset();
      t_monitor();
      t_suspend();
      t_break();
      t_events();
      t_fill();
      print_verdict();
   end
endmodule // tcrm_top_tb_top
